// ### verilog/cimb_defines.svh
// register offsets, write masks and reset values of the common interrupt mask bank
`ifndef CIMB_DEFINES_SVH
`define CIMB_DEFINES_SVH
`define CIMB_NUM_MASK 5
`define CIMB_IDX_SYSTEM_CLOCK_IRQ_MASK_MASK 12'h10C
`define CIMB_IDX_AUX_MASK 12'h10D
`define CIMB_IDX_REF_A_PAIR_IRQ_MASK_MASK 12'h10E
`define CIMB_IDX_REF_B_PAIR_IRQ_MASK_MASK 12'h10F
`define CIMB_IDX_TS_MASK 12'h110
`define CIMB_IDX_STAT_BASE 12'h120
`define CIMB_MASK_RESET 8'h00
`define CIMB_AUX_WMASK 8'h3F
`define CIMB_TS_WMASK 8'h1F
`define CIMB_HTRANS_NONSEQ 2'h2
`define CIMB_HSIZE_WORD 3'h2
`endif

// ### verilog/cimb_pkg.sv
// types shared by the common interrupt mask bank
package cimb_pkg;
  typedef logic [7:0] cimb_byte_t;
  // one byte of event flags for each of the five banks
  typedef struct packed {
    cimb_byte_t timestamp;
    cimb_byte_t ref_b;
    cimb_byte_t ref_a;
    cimb_byte_t aux_loop;
    cimb_byte_t system_clock;
  } cimb_bank_t;
  // latched address phase of an ahb transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] index;
  } cimb_aphase_t;
endpackage : cimb_pkg

// ### verilog/cimb_irq_mask_bank.sv
// common interrupt mask bank with sticky status behind an ahb-lite slave
//
// Contract
// - system clock mask bit 7 gates unlock event
// - bit 6 gates system clock stable event
// - bit 5 gates system clock locked event
// - bit 4 gates calibration inactive event
// - bit 3 gates calibration active event
// - bit 2 gates watchdog timeout event
// - bit 1 gates loader fault event
// - bit 0 gates loader complete event
// - aux bit 5 gates skew limit event
// - aux bit 4 gates temperature warning event
// - aux bit 3 gates compensation unfault event
// - aux bit 2 gates compensation fault event
// - aux bit 0 gates compensation lock event
// - ref a bit 0 gates ref a fault
// - ref b bit 6 gates complement validated
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
`include "cimb_defines.svh"
module cimb_irq_mask_bank
  import cimb_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // event pulses from the surrounding logic, same clock
  input wire cimb_bank_t event_in,
  // interrupt and mask view
  output logic irq_out,
  output cimb_bank_t mask_out
);

  // elaboration check: the word index needs address bits 13..2
  if (ADDR_W < 14) begin : g_addr_w_check
    $error("cimb_irq_mask_bank: ADDR_W must be at least 14");
  end

  cimb_bank_t mask_reg, mask_next;
  cimb_bank_t stat_reg, stat_next;
  cimb_aphase_t aph_reg, aph_next;
  logic [31:0] rdata_reg, rdata_next;
  cimb_bank_t wr_mask;
  cimb_bank_t rd_clear;
  logic [11:0] word_idx;
  logic take;

  // address phase qualification
  assign word_idx = haddr_in[13:2];
  assign take = hsel_in && hready_in && (htrans_in == `CIMB_HTRANS_NONSEQ)
    && (hsize_in == `CIMB_HSIZE_WORD);

  // writable bits per register; reserved bits stay zero
  assign wr_mask = '{timestamp: `CIMB_TS_WMASK, ref_b: 8'hFF, ref_a: 8'hFF,
                     aux_loop: `CIMB_AUX_WMASK, system_clock: 8'hFF};

  // bus, mask and read-data next state
  always_comb begin
    aph_next = '0;
    mask_next = mask_reg;
    rdata_next = 32'h0000_0000;
    rd_clear = '0;
    if (take) begin
      aph_next.valid = 1'b1;
      aph_next.write = hwrite_in;
      aph_next.index = word_idx;
      if (!hwrite_in) begin
        case (word_idx)
          `CIMB_IDX_SYSTEM_CLOCK_IRQ_MASK_MASK: rdata_next[7:0] = mask_reg.system_clock;
          `CIMB_IDX_AUX_MASK: rdata_next[7:0] = mask_reg.aux_loop;
          `CIMB_IDX_REF_A_PAIR_IRQ_MASK_MASK: rdata_next[7:0] = mask_reg.ref_a;
          `CIMB_IDX_REF_B_PAIR_IRQ_MASK_MASK: rdata_next[7:0] = mask_reg.ref_b;
          `CIMB_IDX_TS_MASK: rdata_next[7:0] = mask_reg.timestamp;
          `CIMB_IDX_STAT_BASE: begin
            rdata_next[7:0] = stat_reg.system_clock;
            rd_clear.system_clock = 8'hFF;
          end
          `CIMB_IDX_STAT_BASE + 12'h001: begin
            rdata_next[7:0] = stat_reg.aux_loop;
            rd_clear.aux_loop = 8'hFF;
          end
          `CIMB_IDX_STAT_BASE + 12'h002: begin
            rdata_next[7:0] = stat_reg.ref_a;
            rd_clear.ref_a = 8'hFF;
          end
          `CIMB_IDX_STAT_BASE + 12'h003: begin
            rdata_next[7:0] = stat_reg.ref_b;
            rd_clear.ref_b = 8'hFF;
          end
          `CIMB_IDX_STAT_BASE + 12'h004: begin
            rdata_next[7:0] = stat_reg.timestamp;
            rd_clear.timestamp = 8'hFF;
          end
          default: rdata_next = 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
    // data phase write; masks steer which events interrupt
    if (aph_reg.valid && aph_reg.write) begin
      case (aph_reg.index)
        `CIMB_IDX_SYSTEM_CLOCK_IRQ_MASK_MASK:
          mask_next.system_clock = hwdata_in[7:0] & wr_mask.system_clock;
        `CIMB_IDX_AUX_MASK:
          mask_next.aux_loop = hwdata_in[7:0] & wr_mask.aux_loop;
        `CIMB_IDX_REF_A_PAIR_IRQ_MASK_MASK:
          mask_next.ref_a = hwdata_in[7:0] & wr_mask.ref_a;
        `CIMB_IDX_REF_B_PAIR_IRQ_MASK_MASK:
          mask_next.ref_b = hwdata_in[7:0] & wr_mask.ref_b;
        `CIMB_IDX_TS_MASK:
          mask_next.timestamp = hwdata_in[7:0] & wr_mask.timestamp;
        default: mask_next = mask_reg; // unmapped writes ignored
      endcase
    end
  end

  // sticky status: events latch on all but reserved bits whatever the mask, a new event beats the read clear
  always_comb begin
    stat_next = (stat_reg & ~rd_clear) | (event_in & wr_mask);
  end

  // register all state; clock enable freezes everything
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_reg <= {`CIMB_NUM_MASK{`CIMB_MASK_RESET}};
      stat_reg <= '0;
      aph_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else if (clk_en_in) begin
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      aph_reg <= aph_next;
      rdata_reg <= rdata_next;
    end
  end

  // interrupt: any status bit whose mask bit is one
  // system clock bits 7..0: unlock, stable, locked, cal idle, cal run, wdog, nvm fault, nvm done
  // aux bits: 4 temperature, 3 unfault, 2 fault, 0 lock
  assign irq_out = |(stat_reg & mask_reg);

  // bus answers: zero wait states, always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_reg;
  assign mask_out = mask_reg;

endmodule : cimb_irq_mask_bank

// ### dv/cimb_irq_chk.sv
// port assertions for the common interrupt mask bank
`timescale 1ns/100ps
module cimb_irq_chk
  import cimb_pkg::*;
#(parameter int ADDR_W = 14) (
  input wire logic clk_sys_in, nrst_in, clk_en_in, hsel_in, hwrite_in, hready_in,
  input wire logic [ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in, hrdata_out,
  input wire logic hreadyout_out, hresp_out, irq_out,
  input wire cimb_bank_t event_in, mask_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // address phase taken by the slave
  wire take = hsel_in && hready_in && clk_en_in && htrans_in == 2'h2 && hsize_in == 3'h2;
  wire wr = take && hwrite_in;
  a_irq_event: assert property (clk_en_in && |(event_in & mask_out) && !$past(wr) |=> irq_out)
    else $error("unmasked event gave no irq");
  a_irq_masked: assert property (mask_out == '0 |-> !irq_out)
    else $error("irq with all masks clear");
  a_irq_sticky: assert property (irq_out && !take && !$past(wr) |=> irq_out)
    else $error("irq dropped without a read");
  a_sys_write: assert property (wr && haddr_in == 14'h430 ##1 1'b1 |=>
    mask_out.system_clock == $past(hwdata_in[7:0])) else $error("mask write lost");
  a_mask_hold: assert property (!wr |-> ##2 $stable(mask_out))
    else $error("mask changed without write");
  a_rsvd_zero: assert property (mask_out.aux_loop[7:6] == 2'h0 && mask_out.timestamp[7:5] == 3'h0)
    else $error("reserved mask bit set");
  a_rd_upper: assert property (take && !hwrite_in |=> hrdata_out[31:8] == 24'h0)
    else $error("read upper bits not zero");
  a_rd_idle: assert property (!(take && !hwrite_in) |=> hrdata_out == 32'h0)
    else $error("read data outside data phase");
  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("slave not ready or not okay");
endmodule : cimb_irq_chk
bind cimb_irq_mask_bank cimb_irq_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### dv/cimb_host_bfm.sv
// host bus master model issuing single word transfers
`timescale 1ns/100ps
module cimb_host_bfm (
  input wire logic clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out = 1'b0,
  output logic hwrite_out = 1'b0,
  output logic [13:0] haddr_out = 14'h0,
  output logic [1:0] htrans_out = 2'h0,
  output logic [2:0] hsize_out = 3'h2,
  output logic [31:0] hwdata_out = 32'h0
);
  // address phase held until ready, then data phase held until ready
  task xfer(input logic w, input logic [13:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel_out <= 1'b1;
    htrans_out <= 2'h2;
    hwrite_out <= w;
    haddr_out <= a;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge clk_in); while (hready_in !== 1'b1);
    r = hrdata_in;
  endtask : xfer
endmodule : cimb_host_bfm

// ### dv/tb_top.sv
// self-checking bench for the common interrupt mask bank
`timescale 1ns/100ps
module tb_top;
  import cimb_pkg::*;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, hsel, hwrite, hready, hresp, irq;
  logic [13:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  cimb_bank_t ev = '0, mask;
  int error_cnt = 0, total_checks = 0;
  logic [13:0] ra [6] = '{14'h430, 14'h434, 14'h438, 14'h43C, 14'h440, 14'h444};
  logic [7:0] rw [6] = '{8'hFF, 8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'hFF};
  logic [7:0] rx [6] = '{8'hFF, 8'h3F, 8'hA5, 8'h5A, 8'h1F, 8'h00};
  cimb_irq_mask_bank u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(1'b1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .event_in(ev), .irq_out(irq), .mask_out(mask));
  cimb_host_bfm u_host (.clk_in(clk_sys_in), .hready_in(hready), .hrdata_in(hrdata),
    .hsel_out(hsel), .hwrite_out(hwrite), .haddr_out(haddr), .htrans_out(htrans),
    .hsize_out(hsize), .hwdata_out(hwdata));
  initial forever #10 clk_sys_in = ~clk_sys_in;
  // compare and count
  task chk(input string n, input logic [39:0] e, input logic [39:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // pulse an event, check irq, read status and see irq cleared
  task evt(input cimb_bank_t e, input logic [13:0] a, input logic x, input logic [7:0] s);
    ev <= e;
    @(posedge clk_sys_in);
    ev <= '0;
    #1 chk("irq", x, irq);
    @(posedge clk_sys_in);
    u_host.xfer(1'b0, a, 32'h0, rd);
    chk("status", s, rd);
    #1 chk("irq cleared", 1'b0, irq);
    @(posedge clk_sys_in);
  endtask : evt
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // watchdog far beyond the expected run
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    #1 chk("mask reset", 40'h0, mask);
    $display("reset test done");
    @(posedge clk_sys_in);
    // temperature mask goes in before any event arrives
    for (int i = 0; i < 6; i++) begin
      u_host.xfer(1'b1, ra[i], {24'h0, rw[i]}, rd);
      u_host.xfer(1'b0, ra[i], 32'h0, rd);
      chk("mask readback", {32'h0, rx[i]}, rd);
    end
    $display("row tests done");
    evt(40'h00005A0000, 14'h488, 1'b0, 8'h5A);
    evt(40'h0000000080, 14'h480, 1'b1, 8'h80);
    evt(40'h0000001000, 14'h484, 1'b1, 8'h10);
    evt(40'hFF00000000, 14'h490, 1'b1, 8'h1F);
    evt(40'h0040000000, 14'h48C, 1'b1, 8'h40);
    $display("event tests done");
    print_verdict();
  end
endmodule : tb_top
